// ===== pkg/isp_map.svh
// Constants for the ISA host slave port: decode values and bit positions.
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH
`define ISP_DISP_LO_TOP7 7'h05
`define ISP_DISP_HI_TOP7 7'h05
`define ISP_LOW_BYTE_MSB 7
`define ISP_HIGH_BYTE_LSB 8
`define ISP_IDX_RST 8'h00
`define ISP_DATA_RST 8'h00
`define ISP_HIADDR_RST 7'h00
`define ISP_IOQ_RST 16'h0000
`define ISP_FULL_RST 24'h000000
`define ISP_IO_BASE 16'h03C0
`define ISP_IO_LAST 16'h03DF
`endif

// ===== pkg/isp_pkg.sv
// Types shared by the ISA host slave port.
package isp_pkg;
  typedef struct packed {
    logic iow_n;
    logic smemr_n;
    logic refresh_n;
    logic bale;
    logic [6:0] la;
    logic [16:0] sa;
    logic [15:0] sd;
  } isp_bus_t;
  typedef struct packed {
    logic wr;
    logic wide;
    logic [15:0] port;
    logic [15:0] data;
  } isp_wr_t;
endpackage : isp_pkg

// ===== design/isp_edge.sv
// Rising edge detector for an active-low strobe.
`timescale 1ns/1ps
module isp_edge (
  input wire logic clk,
  input wire logic rstn,
  input wire logic strobe_n,
  output logic rise
);
  logic prev;
  logic next_prev;
  always_comb begin
    next_prev = strobe_n;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end
  assign rise = strobe_n && !prev;
endmodule : isp_edge

// ===== design/isp_port.sv
// ISA host slave port: I/O writes, upper address latch, 16-bit memory select.
// Notes on behaviour
// - Capture data at write strobe rising edge.
// - Wide index write: index low, data high.
// - Latched upper plus low lines form 24 bits.
// - Latch transparent while enable high, holds after.
// - Drive 16-bit memory select for capable addresses.
// - Display window only when sole adapter set.
// - Ignore memory reads during refresh.
`timescale 1ns/1ps
`include "isp_map.svh"
module isp_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_reset,
  input wire isp_pkg::isp_bus_t bus,
  input wire logic sole_adapter_select_bit,
  output isp_pkg::isp_wr_t wr_out,
  output logic [7:0] index_reg,
  output logic [7:0] data_reg,
  output logic [23:0] full_addr,
  output logic memcs16_n_o,
  output logic memcs16_n_oe,
  output logic mem_rd
);
  import isp_pkg::*;

  logic iow_rise;
  logic [6:0] hi_addr;
  logic [6:0] next_hi_addr;
  logic [7:0] next_index;
  logic [7:0] next_data;
  isp_wr_t next_wr;
  logic [23:0] next_full;
  logic next_cs_oe;
  logic next_mem_rd;
  logic [15:0] io_q;
  logic [15:0] io_pend;
  logic next_cs_o;
  logic [15:0] next_io_q;

  function automatic logic in_range(input logic [15:0] a);
    in_range = (a >= `ISP_IO_BASE) && (a <= `ISP_IO_LAST);
  endfunction : in_range

  function automatic logic disp_hit(input logic [6:0] top);
    // Display window A0000-BFFFF: bits 23:17 equal 7'h05.
    disp_hit = (top >= `ISP_DISP_LO_TOP7) && (top <= `ISP_DISP_HI_TOP7);
  endfunction : disp_hit

  // The live strobe is compared with its last sample, so its rise is found at the
  // first clock after the host lets it go high; the port seen while it was low is kept for that edge.
  isp_edge i_isp_edge (
    .clk(clk),
    .rstn(rstn),
    .strobe_n(bus.iow_n),
    .rise(iow_rise)
  );
  assign io_pend = io_q;

  // I/O write group. A write is taken only on a found rise with an
  // in-range port, so a strobe cut short by reset is never half applied.
  always_comb begin
    next_io_q = bus.iow_n ? io_q : bus.sa[15:0];
    next_index = index_reg;
    next_data = data_reg;
    next_wr = '0;
    if (iow_rise && in_range(io_pend)) begin
      next_wr.wr = 1'b1;
      next_wr.port = io_pend;
      next_wr.data = bus.sd;
      // No byte enable reaches this port, so every even port write is
      // taken as a 16-bit index-plus-data write.
      next_wr.wide = !io_pend[0];
      if (!io_pend[0]) begin
        next_index = bus.sd[`ISP_LOW_BYTE_MSB:0];
        next_data = bus.sd[15:`ISP_HIGH_BYTE_LSB];
      end else begin
        next_data = bus.sd[`ISP_LOW_BYTE_MSB:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || bus_reset) begin
      io_q <= `ISP_IOQ_RST;
      index_reg <= `ISP_IDX_RST;
      data_reg <= `ISP_DATA_RST;
      wr_out <= '0;
    end else begin
      io_q <= next_io_q;
      index_reg <= next_index;
      data_reg <= next_data;
      wr_out <= next_wr;
    end
  end

  // Address group: the upper latch, the joined address and the 16-bit
  // memory select that is decoded from the latch.
  always_comb begin
    next_hi_addr = bus.bale ? bus.la : hi_addr;
    next_full = {next_hi_addr, bus.sa};
    // The select is registered from the latch's next value, so it changes
    // on the same clock as the upper latch.
    next_cs_oe = sole_adapter_select_bit && disp_hit(next_hi_addr);
  end

  always_ff @(posedge clk) begin
    if (!rstn || bus_reset) begin
      hi_addr <= `ISP_HIADDR_RST;
      full_addr <= `ISP_FULL_RST;
      memcs16_n_oe <= 1'b0;
    end else begin
      hi_addr <= next_hi_addr;
      full_addr <= next_full;
      memcs16_n_oe <= next_cs_oe;
    end
  end

  // Memory read group. Reads are dropped while refresh is requested, and
  // the open-collector select pin only ever drives low.
  always_comb begin
    next_mem_rd = !bus.smemr_n && bus.refresh_n;
    next_cs_o = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rstn || bus_reset) begin
      mem_rd <= 1'b0;
      memcs16_n_o <= 1'b0;
    end else begin
      mem_rd <= next_mem_rd;
      memcs16_n_o <= next_cs_o;
    end
  end

  // Write path checks.
  range_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_out.wr |-> in_range(wr_out.port))
    else $error("write outside range accepted");
  wr_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_out.wr |=> !wr_out.wr)
    else $error("write record stood longer than one cycle");
  wide_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_out.wr |-> wr_out.wide == !wr_out.port[0])
    else $error("write width does not follow the port");
  capture_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    (iow_rise && in_range(io_q) && !io_q[0])
    |=> index_reg == $past(bus.sd[7:0]))
    else $error("index byte not stored");
  high_byte_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    (iow_rise && in_range(io_q) && !io_q[0])
    |=> data_reg == $past(bus.sd[15:8]))
    else $error("data byte of a wide write not stored");
  odd_port_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    (iow_rise && in_range(io_q) && io_q[0])
    |=> data_reg == $past(bus.sd[7:0]))
    else $error("data of an odd port write not stored");
  index_hold_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    (iow_rise && in_range(io_q) && io_q[0])
    |=> $stable(index_reg))
    else $error("odd port write changed the index");
  refuse_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    (iow_rise && !in_range(io_q))
    |=> $stable(index_reg) && $stable(data_reg) && !wr_out.wr)
    else $error("refused write changed a register");

  // Address path checks.
  latch_open_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    bus.bale |=> hi_addr == $past(bus.la))
    else $error("upper latch not transparent");
  latch_hold_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    !bus.bale |=> $stable(hi_addr))
    else $error("upper latch lost its value");
  addr_join_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    1'b1 |=> full_addr == {hi_addr, $past(bus.sa)})
    else $error("full address not joined from latch and low lines");

  // Select and read checks.
  memcs_a: assert property (@(posedge clk) disable iff (!rstn)
    memcs16_n_oe |-> $past(sole_adapter_select_bit))
    else $error("memory select driven without sole adapter bit");
  window_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    ($past(sole_adapter_select_bit) && hi_addr == `ISP_DISP_LO_TOP7)
    |-> memcs16_n_oe)
    else $error("memory select missing for the display window");
  window_only_a: assert property (@(posedge clk) disable iff (!rstn)
    memcs16_n_oe |-> disp_hit(hi_addr))
    else $error("memory select driven outside the display window");
  pin_low_a: assert property (@(posedge clk) disable iff (!rstn)
    !memcs16_n_o)
    else $error("memory select pin driven high");
  refresh_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(bus.refresh_n) |-> !mem_rd)
    else $error("memory read taken during refresh");
  read_a: assert property (@(posedge clk)
    disable iff (!rstn || bus_reset)
    ($past(rstn) && !$past(bus_reset) && !$past(bus.smemr_n)
      && $past(bus.refresh_n)) |-> mem_rd)
    else $error("memory read not taken outside refresh");
  // The select is cleared with the registers, so a card held in reset
  // leaves the shared select line to the bus pull-up.
  reset_a: assert property (@(posedge clk) bus_reset |=> !memcs16_n_oe
    && !wr_out.wr && !mem_rd)
    else $error("outputs active in reset");

  wr_c: cover property (@(posedge clk) wr_out.wr && wr_out.wide);
  cs_c: cover property (@(posedge clk) memcs16_n_oe);
  rd_c: cover property (@(posedge clk) mem_rd);
  refuse_c: cover property (@(posedge clk) iow_rise && !in_range(io_q));
  hold_c: cover property (@(posedge clk) $fell(bus.bale));
endmodule : isp_port

// ===== tb/isp_host.sv
// Host model that drives the ISA strobes, address and data lines.
`timescale 1ns/1ps
module isp_host (
  input wire logic clk,
  output isp_pkg::isp_bus_t bus
);
  import isp_pkg::*;
  initial bus = {4'hE, 7'h00, 17'h00000, 16'hFFFF};
  task automatic io_wr(input logic [15:0] p, input logic [15:0] d);
    @(negedge clk);
    bus.sa = {1'b0, p};
    bus.sd = d;
    bus.iow_n = 1'b0;
    @(negedge clk);
    bus.iow_n = 1'b1;
    @(negedge clk);
    // Released data lines float: the high byte to its pull-ups, the low
    // byte to a value unlike the one written.
    bus.sd = {8'hFF, ~d[7:0]};
  endtask : io_wr
  task automatic latch(input logic [6:0] a, input logic [16:0] s);
    @(negedge clk);
    {bus.bale, bus.la, bus.sa} = {1'b1, a, s};
    repeat (2) @(negedge clk);
    bus.bale = 1'b0;
    @(negedge clk);
    bus.la = ~a;
  endtask : latch
  task automatic rd_mem(input logic r);
    @(negedge clk);
    {bus.smemr_n, bus.refresh_n} = {1'b0, r};
    repeat (2) @(negedge clk);
  endtask : rd_mem
  task automatic rd_end();
    {bus.smemr_n, bus.refresh_n} = 2'b11;
    @(negedge clk);
  endtask : rd_end
endmodule : isp_host

// ===== tb/isp_port_tb_top.sv
// Self-checking testbench for the ISA host slave port.
`timescale 1ns/1ps
module isp_port_tb_top;
  import isp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_reset = 1'b0;
  logic sole = 1'b0;
  isp_bus_t bus;
  isp_wr_t wr_out;
  logic [7:0] index_reg, data_reg, ei, ed;
  logic [23:0] full_addr;
  logic memcs16_n_o, memcs16_n_oe, mem_rd;
  logic [31:0] s = 32'd2515;
  logic [15:0] p, d;
  logic [6:0] a;
  logic [15:0] cp [4] = '{16'h03BF, 16'h03C0, 16'h03DF, 16'h03E0};
  int error_cnt = 0, comparisons = 0, wr_seen = 0, wr_exp = 0;
  logic hit;
  isp_wr_t wr_last = '0;
  initial forever #12.5 clk = ~clk;
  isp_host i_host (.clk, .bus);
  isp_port i_isp_port (.clk, .rstn, .bus_reset, .bus,
    .sole_adapter_select_bit(sole), .wr_out, .index_reg, .data_reg,
    .full_addr, .memcs16_n_o, .memcs16_n_oe, .mem_rd);
  // Outputs are taken at the falling edge, clear of the launching edge.
  always @(negedge clk) begin
    if (wr_out.wr === 1'b1) begin
      wr_seen++;
      wr_last = wr_out;
    end
  end
  function automatic logic exp_hit(input logic [15:0] a);
    return a >= 16'h03C0 && a <= 16'h03DF;
  endfunction : exp_hit
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] v, e);
    comparisons++;
    if (v !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 3000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {ei, ed} = 16'h0000;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // Range edges first, then random ports on both sides of the window.
    for (int i = 0; i < 60; i++) begin
      p = (i < 4) ? cp[i] : 16'h03B0 + 16'(rnd() % 64);
      d = 16'(rnd());
      hit = exp_hit(p);
      i_host.io_wr(p, d);
      if (hit) begin
        wr_exp++;
        if (p[0]) ed = d[7:0];
        else {ed, ei} = d;
      end
      repeat (2) @(negedge clk);
      chk("index", index_reg, ei);
      chk("data", data_reg, ed);
      if (hit) begin
        chk("wr_port", wr_last.port, p);
        chk("wr_data", wr_last.data, d);
        chk("wr_wide", wr_last.wide, !p[0]);
      end
    end
    chk("writes", wr_seen, wr_exp);
    for (int i = 0; i < 20; i++) begin
      a = (i < 2) ? 7'h05 : 7'(rnd());
      sole = (i < 2) ? i[0] : 1'(rnd());
      i_host.latch(a, 17'(rnd()));
      repeat (3) @(negedge clk);
      chk("addr", full_addr, {a, i_host.bus.sa});
      chk("mcs_oe", memcs16_n_oe, a == 7'h05 && sole);
      chk("mcs_o", memcs16_n_o, 1'b0);
    end
    for (int r = 0; r < 2; r++) begin
      i_host.rd_mem(r[0]);
      chk("mem_rd", mem_rd, r[0]);
      i_host.rd_end();
      chk("mem_idle", mem_rd, 1'b0);
    end
    sole = 1'b1;
    i_host.latch(7'h05, 17'h00000);
    chk("mcs_on", memcs16_n_oe, 1'b1);
    bus_reset = 1'b1;
    repeat (2) @(negedge clk);
    bus_reset = 1'b0;
    chk("rst", {index_reg, data_reg, memcs16_n_oe, mem_rd}, 18'h00000);
    chk("rst_addr", full_addr, 24'h000000);
    chk("rst_wr", wr_out.wr, 1'b0);
    repeat (2) @(negedge clk);
    chk("rst_hold", memcs16_n_oe, 1'b0);
    i_host.io_wr(16'h03C5, 16'h5AA5);
    repeat (2) @(negedge clk);
    chk("post_rst", data_reg, 8'hA5);
    tally_and_finish();
  end
endmodule : isp_port_tb_top
